/* include/rsld_defs.svh */
`ifndef RSLD_DEFS_SVH
`define RSLD_DEFS_SVH

// Interface codes of the external port strap pair
`define RSLD_IF_MII      2'h0
`define RSLD_IF_RMII     2'h1
`define RSLD_IF_RSVD     2'h2
`define RSLD_IF_RGMII    2'h3

// Management interface codes
`define RSLD_MG_MDIO     2'h0
`define RSLD_MG_I2C      2'h1
`define RSLD_MG_SPI      2'h2

// Integrated PHY strap codes
`define RSLD_PHY_RSVD    2'h0
`define RSLD_PHY_AN_EEE  2'h1
`define RSLD_PHY_F_MDIX  2'h2
`define RSLD_PHY_F_MDI   2'h3

// Strap defaults, order of rsld_strap_s
`define RSLD_STRAP_RST   12'hF04

// Widths of the pin groups
`define RSLD_LED_W       4

`endif

/* include/rsld_pkg.sv */
`include "rsld_defs.svh"

package rsld_pkg;

	// External port interface type
	typedef enum logic [1:0] {
		RSLD_MII   = `RSLD_IF_MII,
		RSLD_RMII  = `RSLD_IF_RMII,
		RSLD_XRSV  = `RSLD_IF_RSVD,
		RSLD_RGMII = `RSLD_IF_RGMII
	} rsld_if_e;

	// Host management interface
	typedef enum logic [1:0] {
		RSLD_MDIO = `RSLD_MG_MDIO,
		RSLD_I2C  = `RSLD_MG_I2C,
		RSLD_SPI  = `RSLD_MG_SPI
	} rsld_mgmt_e;

	// Raw strap levels as seen on the pins
	typedef struct packed {
		logic       switch_start;
		logic       inband;
		logic       role;
		logic       speed;
		logic [1:0] ext_if;
		logic [1:0] mgmt;
		logic [1:0] phy_cfg;
		logic [1:0] test;
	} rsld_strap_s;

	// Decoded configuration for consumers
	typedef struct packed {
		logic       inband_en;
		rsld_if_e   ext_if;
		logic       if_reserved;
		logic       mii_mac;
		logic       mii_phy;
		logic       rmii_ref_out;
		logic       rmii_ref_in;
		logic       spd_1000;
		rsld_mgmt_e mgmt;
		logic       an_en;
		logic       eee_adv;
		logic       force_100fd;
		logic       auto_mdix;
		logic       mdix_fixed;
		logic       phy_reserved;
		logic       factory_test;
	} rsld_cfg_s;

endpackage

/* src/rsld_top.sv */
`timescale 1ns/10ps
module rsld_top
	import rsld_pkg::*;
#(
	parameter int LED_W = `RSLD_LED_W
) (
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic              sw_reset_act,
	input  wire logic              pwrdn_act,
	input  wire logic              start_bit,
	input  wire rsld_strap_s       strap_pins,
	input  wire logic [LED_W-1:0]  led_func,
	input  wire logic              wake_func,
	output rsld_cfg_s              cfg_r,
	output logic                   fwd_en_r,
	output logic                   strap_valid_r,
	output logic [LED_W-1:0]       led_pin_out_r,
	output logic                   led_pin_oe_r,
	output logic                   wake_event_pin_out_r,
	output logic                   wake_event_pin_oe_r
);

	// Window while pins act as straps, then run
	typedef enum logic [1:0] {
		RSLD_ST_WIN = 2'h1,
		RSLD_ST_RUN = 2'h2
	} rsld_state_e;

	rsld_state_e state_r;            // Window or run
	rsld_state_e state_nxt;          // Next state
	rsld_strap_s strap_r;            // Held strap image
	rsld_strap_s strap_nxt;          // Next strap image
	rsld_cfg_s   cfg_nxt;            // Next decoded setting
	logic        fwd_nxt;            // Next forward enable

	// Decode control wires
	wire logic        in_win;        // In strap window
	wire logic        hold_req;      // Reset or power-down active
	wire logic        capture;       // Sampling edge
	wire logic        leave_run;     // Re-enter strap window
	wire rsld_strap_s src;           // Strap source for decode
	wire logic        is_mii;        // MII selected
	wire logic        is_rmii;       // RMII selected
	wire logic        phy_forced;    // Forced 100 full duplex

	assign in_win    = (state_r == RSLD_ST_WIN);
	assign hold_req  = sw_reset_act | pwrdn_act;
	// End of window
	// Capture once both reset and power-down have ended
	assign capture   = in_win & ~hold_req;
	// Power-down or reset
	// Any later reset or power-down reopens the window
	assign leave_run = ~in_win & hold_req;

	// Decode from the pins at the capture edge, else the held image
	assign src = capture ? strap_pins : strap_r;

	assign is_mii  = (src.ext_if == `RSLD_IF_MII);
	assign is_rmii = (src.ext_if == `RSLD_IF_RMII);

	// Forced PHY codes
	// Upper bit set means the two forced codes
	assign phy_forced = src.phy_cfg[1];

	// Next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			// Waiting for reset cycle to end
			RSLD_ST_WIN: begin
				if (capture) begin
					state_nxt = RSLD_ST_RUN;
				end
			end
			// Configuration active
			RSLD_ST_RUN: begin
				if (leave_run) begin
					state_nxt = RSLD_ST_WIN;
				end
			end
			// Illegal one-hot code recovers to window
			default: begin
				state_nxt = RSLD_ST_WIN;
			end
		endcase
	end

	// Hold straps
	// Only a capture edge may change the image
	assign strap_nxt = capture ? strap_pins : strap_r;

	// Limitation: during a software window cfg_r keeps the
	// last image, so consumers must gate on strap_valid_r
	// Decoded settings, all taken from src
	always_comb begin
		cfg_nxt = '0;
		cfg_nxt.inband_en    = ~src.inband;
		cfg_nxt.ext_if       = rsld_if_e'(src.ext_if);
		// Reserved code flagged, port left without a role
		cfg_nxt.if_reserved  = (src.ext_if == `RSLD_IF_RSVD);
		// MII role
		// Role has no meaning outside MII and RMII
		cfg_nxt.mii_mac      = is_mii & src.role;
		cfg_nxt.mii_phy      = is_mii & ~src.role;
		cfg_nxt.rmii_ref_out = is_rmii & ~src.role;
		cfg_nxt.rmii_ref_in  = is_rmii & src.role;
		cfg_nxt.spd_1000     = ~src.speed;
		// Management select
		// Upper bit alone picks SPI
		if (src.mgmt[1]) begin
			cfg_nxt.mgmt = RSLD_SPI;
		end else if (src.mgmt[0]) begin
			cfg_nxt.mgmt = RSLD_I2C;
		end else begin
			cfg_nxt.mgmt = RSLD_MDIO;
		end
		cfg_nxt.an_en        = (src.phy_cfg == `RSLD_PHY_AN_EEE);
		cfg_nxt.eee_adv      = (src.phy_cfg == `RSLD_PHY_AN_EEE);
		// Auto crossover only while negotiating
		cfg_nxt.auto_mdix    = (src.phy_cfg == `RSLD_PHY_AN_EEE);
		cfg_nxt.force_100fd  = phy_forced;
		// Code 10 crossed pinout, 11 straight
		cfg_nxt.mdix_fixed   = (src.phy_cfg == `RSLD_PHY_F_MDIX);
		// Reserved code leaves every PHY option off
		cfg_nxt.phy_reserved = (src.phy_cfg == `RSLD_PHY_RSVD);
		// Factory test
		// Either test strap high selects test
		cfg_nxt.factory_test = |src.test;
	end

	// Start gating
	// No forwarding inside the window; start bit overrides strap 0
	// Start bit is a live register bit, so it is never latched
	assign fwd_nxt = ~leave_run & (capture | ~in_win)
		& (src.switch_start | start_bit);

	// Active low reset
	// State and straps reset to documented defaults
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= RSLD_ST_WIN;
			strap_r <= `RSLD_STRAP_RST;
		end else begin
			state_r <= state_nxt;
			strap_r <= strap_nxt;
		end
	end

	// Registered outputs
	// Decode lands in the flops on the capture edge itself
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cfg_r         <= '0;
			fwd_en_r      <= 1'b0;
			strap_valid_r <= 1'b0;
		end else begin
			cfg_r         <= cfg_nxt;
			fwd_en_r      <= fwd_nxt;
			strap_valid_r <= (state_nxt == RSLD_ST_RUN);
		end
	end

	// Shared pin drivers
	// Drive released only once run is entered, so a strap
	// resistor is never fought during sampling
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			led_pin_oe_r         <= 1'b0;
			wake_event_pin_oe_r  <= 1'b0;
			led_pin_out_r        <= '0;
			wake_event_pin_out_r <= 1'b0;
		end else begin
			led_pin_oe_r         <= (state_nxt == RSLD_ST_RUN);
			wake_event_pin_oe_r  <= (state_nxt == RSLD_ST_RUN);
			led_pin_out_r        <= led_func;
			wake_event_pin_out_r <= wake_func;
		end
	end

	// Checks, all on the system clock
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	AST_SAMPLE: assert property (
		capture |=> strap_r == $past(strap_pins))
		else $error("strap image differs from sampled pins");

	AST_REENTER: assert property (
		leave_run |=> in_win ##0 !led_pin_oe_r)
		else $error("reset or power-down did not reopen window");

	AST_HOLD: assert property (
		!in_win ##1 !in_win |-> $stable(strap_r))
		else $error("strap image changed while running");

	AST_FWD: assert property (
		!in_win && !hold_req && !strap_r.switch_start && !start_bit
		|=> !fwd_en_r)
		else $error("forwarding without start strap or bit");

	AST_FWD_WIN: assert property (
		in_win && $past(in_win) |-> !fwd_en_r)
		else $error("forwarding during strap window");

	AST_INBAND: assert property (
		capture |=> cfg_r.inband_en == !$past(strap_pins.inband))
		else $error("inband enable wrong polarity");

	AST_ROLE: assert property (
		cfg_r.mii_mac || cfg_r.mii_phy |-> cfg_r.ext_if == RSLD_MII)
		else $error("MII role outside MII");

	AST_RMII: assert property (
		cfg_r.rmii_ref_out |-> cfg_r.ext_if == RSLD_RMII && !cfg_r.rmii_ref_in)
		else $error("RMII reference direction wrong");

	AST_SPEED: assert property (
		capture |=> cfg_r.spd_1000 == !$past(strap_pins.speed))
		else $error("speed select wrong polarity");

	AST_MGMT: assert property (
		capture && strap_pins.mgmt[1] |=> cfg_r.mgmt == RSLD_SPI)
		else $error("upper management bit did not pick SPI");

	AST_PHY: assert property (
		cfg_r.force_100fd |-> !cfg_r.an_en && !cfg_r.auto_mdix)
		else $error("forced mode with autoneg or crossover");

	AST_OE: assert property (
		in_win |-> !led_pin_oe_r && !wake_event_pin_oe_r)
		else $error("shared pin driven during strap window");

	AST_IFCODE: assert property (
		capture |=> cfg_r.ext_if == $past(strap_pins.ext_if)
		&& cfg_r.if_reserved == ($past(strap_pins.ext_if) == `RSLD_IF_RSVD))
		else $error("interface code not taken from straps");

	AST_FWD_START: assert property (
		capture && strap_pins.switch_start |=> fwd_en_r)
		else $error("start strap did not enable forwarding");

	AST_AN: assert property (
		capture && strap_pins.phy_cfg == `RSLD_PHY_AN_EEE
		|=> cfg_r.an_en && cfg_r.eee_adv && !cfg_r.force_100fd)
		else $error("autoneg code not decoded");

	AST_TEST: assert property (
		capture |=> cfg_r.factory_test == |$past(strap_pins.test))
		else $error("factory test select wrong");

	AST_RST_IDLE: assert property (
		disable iff (1'b0) !resetn && $past(!resetn)
		|-> !strap_valid_r && !fwd_en_r && !led_pin_oe_r && !wake_event_pin_oe_r)
		else $error("outputs active during reset");

	AST_VALID: assert property (
		capture |=> strap_valid_r && led_pin_oe_r && wake_event_pin_oe_r)
		else $error("outputs not valid after capture");

	// Main scenarios
	COV_RGMII: cover property (capture ##1 cfg_r.ext_if == RSLD_RGMII);
	COV_FORCE: cover property (capture ##1 cfg_r.force_100fd);
	COV_SWRST: cover property (leave_run ##[1:20] capture);
	COV_START: cover property (!fwd_en_r && !in_win ##1 fwd_en_r);
	COV_PWRDN: cover property (pwrdn_act && !in_win ##1 in_win);

endmodule

/* tb/rsld_strap_model.sv */
`timescale 1ns/10ps
// Board strap resistors behind shared pins
module rsld_strap_model
	import rsld_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        drive_oe,
	input  wire rsld_strap_s board,
	output rsld_strap_s      strap_pins
);
	// Pattern flipping every cycle while the device drives
	rsld_strap_s flip_r = 12'h5A5;

	// Toggle so that a late sample seldom matches by luck;
	// plain always, as the declaration also initialises it
	always @(posedge sys_clk) begin
		flip_r <= ~flip_r;
	end

	// Resistors seen only while the device drives nothing
	assign strap_pins = drive_oe ? flip_r : board;
endmodule

/* tb/rsld_top_test.sv */
`timescale 1ns/10ps
module rsld_top_test;
	import rsld_pkg::*;
	logic        sys_clk, resetn, sw_reset_act, pwrdn_act, start_bit, wake_func;
	logic [3:0]  led_func, led_pin_out_r;
	rsld_strap_s board, strap_pins;
	rsld_cfg_s   cfg_r, held;
	logic        fwd_en_r, strap_valid_r, led_pin_oe_r, wake_event_pin_out_r, wake_event_pin_oe_r;
	logic [31:0] seed;
	int          err_count, checks;
	// Corner strap sets: every code of each two-bit field
	logic [11:0] corner [4] = '{12'h000, 12'h055, 12'h0AA, 12'hFFF};

	rsld_top rsld_top_inst (.sys_clk(sys_clk), .resetn(resetn), .sw_reset_act(sw_reset_act),
		.pwrdn_act(pwrdn_act), .start_bit(start_bit), .strap_pins(strap_pins),
		.led_func(led_func), .wake_func(wake_func), .cfg_r(cfg_r), .fwd_en_r(fwd_en_r),
		.strap_valid_r(strap_valid_r), .led_pin_out_r(led_pin_out_r),
		.led_pin_oe_r(led_pin_oe_r), .wake_event_pin_out_r(wake_event_pin_out_r),
		.wake_event_pin_oe_r(wake_event_pin_oe_r));

	rsld_strap_model rsld_strap_model_inst (.sys_clk(sys_clk), .drive_oe(led_pin_oe_r),
		.board(board), .strap_pins(strap_pins));

	// Repeatable xorshift source
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic rsld_cfg_s exp_cfg(input rsld_strap_s s);
		rsld_cfg_s c;
		c = '0;
		c.inband_en    = ~s.inband;
		c.ext_if       = rsld_if_e'(s.ext_if);
		c.if_reserved  = (s.ext_if == 2'h2);
		c.mii_mac      = (s.ext_if == 2'h0) & s.role;
		c.mii_phy      = (s.ext_if == 2'h0) & ~s.role;
		c.rmii_ref_out = (s.ext_if == 2'h1) & ~s.role;
		c.rmii_ref_in  = (s.ext_if == 2'h1) & s.role;
		c.spd_1000     = ~s.speed;
		c.mgmt         = rsld_mgmt_e'(s.mgmt[1] ? 2'h2 : {1'h0, s.mgmt[0]});
		c.an_en        = (s.phy_cfg == 2'h1);
		c.eee_adv      = (s.phy_cfg == 2'h1);
		c.auto_mdix    = (s.phy_cfg == 2'h1);
		c.force_100fd  = s.phy_cfg[1];
		c.mdix_fixed   = (s.phy_cfg == 2'h2);
		c.phy_reserved = (s.phy_cfg == 2'h0);
		c.factory_test = |s.test;
		return c;
	endfunction

	// Count a comparison, report a miss at once
	task automatic chk(input logic ok, input string msg);
		checks++;
		if (ok !== 1'h1) begin
			err_count++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask

	// Verdict and end of run
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Wait for capture, bounded; capture must land one edge after release
	task automatic chk_cap(input string name);
		int n;
		n = 0;
		while (strap_valid_r !== 1'h1 && n < 8) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk(n == 1, "capture latency");
		if (n == 8) begin
			end_sim();
		end else begin
			chk(cfg_r === exp_cfg(board), "decoded settings");
			chk(fwd_en_r === (board.switch_start | start_bit), "forward enable");
			chk(led_pin_oe_r === 1'h1 && wake_event_pin_oe_r === 1'h1, "pins back");
			$display("test %s done", name);
		end
	endtask

	// 200 MHz clock
	initial begin
		sys_clk = 1'h0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Main sequence; inputs change 1 ns after the rising edge
	initial begin
		seed = 32'h90E1;
		err_count = 0;
		checks = 0;
		resetn = 1'h0;
		sw_reset_act = 1'h0;
		pwrdn_act = 1'h0;
		start_bit = 1'h0;
		led_func = 4'h0;
		wake_func = 1'h0;
		board = 12'hF04;
		repeat (12) @(posedge sys_clk);
		#1;
		// Outputs idle while reset held low
		chk(strap_valid_r === 1'h0 && fwd_en_r === 1'h0, "reset idle");
		chk(cfg_r === '0 && led_pin_oe_r === 1'h0, "reset outputs");
		resetn = 1'h1;
		chk_cap("power-up");
		for (int i = 0; i < 60; i++) begin
			seed = xs(seed);
			board = (i < 4) ? corner[i] : seed[11:0];
			board.test = 2'h0; // board keeps test straps normal
			start_bit = seed[12];
			led_func = seed[16:13];
			wake_func = seed[17];
			// Hardware reset, software reset or power-down in turn
			if (i % 3 == 0) begin
				resetn = 1'h0;
				#1 chk(strap_valid_r === 1'h0, "async reset");
				chk(cfg_r === '0 && wake_event_pin_oe_r === 1'h0, "reset outputs");
				@(posedge sys_clk);
				#1 resetn = 1'h1;
			end else begin
				sw_reset_act = (i % 3 == 1);
				pwrdn_act = (i % 3 == 2);
				@(posedge sys_clk);
				#1;
				chk(strap_valid_r === 1'h0 && led_pin_oe_r === 1'h0, "window open");
				chk(fwd_en_r === 1'h0, "no forwarding in window");
				sw_reset_act = 1'h0;
				pwrdn_act = 1'h0;
			end
			chk_cap("capture");
			chk(led_pin_out_r === led_func, "led drive");
			chk(wake_event_pin_out_r === wake_func, "wake drive");
			// Straps changed while running must be ignored
			held = cfg_r;
			board = ~board;
			start_bit = ~start_bit;
			repeat (3) @(posedge sys_clk);
			#1;
			chk(cfg_r === held, "held config");
			chk(fwd_en_r === (~board.switch_start | start_bit), "start bit");
		end
		end_sim();
	end
endmodule
